// ==== hw/addr_phase_pkg.sv ====
// shared constants and types for the address-phase link
package addr_phase_pkg;
	localparam int ADDR_HI = 31;
	localparam int ADDR_LO = 3;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int LINE_LO = 5;
	localparam int MASK_BIT = 20;
	localparam int LINE_LO_IDX = LINE_LO - ADDR_LO;
	localparam int MASK_IDX = MASK_BIT - ADDR_LO;
	localparam logic [ADDR_W-1:0] ADDR_RST = 29'h0000000;
	localparam logic [2:0] BEAT_SINGLE = 3'h1;
	localparam logic [2:0] BEAT_BURST = 3'h4;
	// edges after reset release in which no cycle may start
	localparam logic [1:0] RST_SETTLE = 2'h2;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_GAP = 2'b11
	} bus_state_t;
endpackage

// ==== hw/addr_phase_if.sv ====
// wires between the processor end and the chipset end
interface addr_phase_if;
	import addr_phase_pkg::*;
	// address bus and parity, each side drives with its enable
	addr_t cpu_addr;
	logic cpu_addr_oe;
	logic cpu_parity;
	addr_t sys_addr;
	logic sys_addr_oe;
	logic sys_parity;
	addr_t addr;
	logic addr_parity_bit;
	// strobes and controls, cpu to system
	logic cycle_start_strobe_n;
	logic cycle_start_strobe_dup_n;
	logic strobe_oe;
	logic addr_parity_err_n;
	logic bus_surrender_ack;
	// controls, system to cpu
	logic bit20_mask_in_n;
	logic addr_float_req;
	logic snoop_addr_valid_n;
	logic next_addr_req_n;
	logic transfer_ack_n;
	logic backoff_req_n;
	assign addr = cpu_addr_oe ? cpu_addr : sys_addr_oe ? sys_addr : ADDR_RST;
	assign addr_parity_bit = cpu_addr_oe ? cpu_parity : sys_addr_oe ? sys_parity : 1'b0;
	modport cpu (
		output cpu_addr, cpu_addr_oe, cpu_parity, cycle_start_strobe_n,
		cycle_start_strobe_dup_n, strobe_oe, addr_parity_err_n, bus_surrender_ack,
		input addr, addr_parity_bit, bit20_mask_in_n, addr_float_req,
		snoop_addr_valid_n, next_addr_req_n, transfer_ack_n, backoff_req_n
	);
	modport sys (
		output sys_addr, sys_addr_oe, sys_parity, bit20_mask_in_n, addr_float_req,
		snoop_addr_valid_n, next_addr_req_n, transfer_ack_n, backoff_req_n,
		input addr, addr_parity_bit, cycle_start_strobe_n, cycle_start_strobe_dup_n,
		strobe_oe, addr_parity_err_n, bus_surrender_ack, cpu_addr_oe
	);
endinterface

// ==== hw/cpu_addr_phase.sv ====
// processor end: address drive, strobes, masking, snoop capture, parity check
// Functional notes
// - mask input clears address bit twenty
// - system holds async mask two clocks
// - no masking for snoops or writebacks
// - mask ignored in system management state
// - mask near reset release takes effect
// - address held until next-addr or last ack
// - address driven also while bus idles
// - snoop address captured at snoop strobe
// - system drives bits four, three on snoop
// - float address, parity on hold or backoff
// - strobe one clock at cycle start
// - non-pipelined restart one idle state later
// - pipelined strobe one edge after next-addr
// - under hold only writeback cycles start
// - strobe floats on backoff or surrender
// - duplicate strobe mirrors primary strobe
// - cycle in progress completes under hold
// - hold sampled every edge outside reset
// - parity even over itself and 31:5
// - parity driven with address and idle
// - snoop parity mismatch flags error only
// - error pulse one clock after snoop edge
// - backed-off cycle restarts from beginning
module cpu_addr_phase (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// link
	addr_phase_if.cpu bus,
	// core request side
	input wire logic i_req_valid,
	input wire addr_phase_pkg::addr_t i_req_addr,
	input wire logic i_req_burst,
	input wire logic i_req_writeback,
	input wire logic i_sys_mgmt_state,
	input wire logic i_real_mode,
	input wire logic i_hold_req,
	// status to core
	output logic o_req_taken,
	output logic o_cycle_done,
	output logic o_snoop_valid,
	output addr_phase_pkg::addr_t o_snoop_addr
);
	import addr_phase_pkg::*;

	bus_state_t state_ff, nxt_state;
	addr_t addr_ff;
	logic parity_ff;
	logic burst_ff;
	logic [2:0] beats_ff;
	logic strobe_ff;
	logic oe_addr_ff;
	logic oe_strobe_ff;
	logic perr_n_ff;
	logic surrender_ff;
	logic taken_ff;
	logic done_ff;
	logic snoop_v_ff;
	addr_t snoop_addr_ff;
	logic hold_ff;
	logic backoff_ff;
	logic [1:0] settle_ff;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire backoff = ~bus.backoff_req_n;
	wire ack = ~bus.transfer_ack_n;
	wire na = ~bus.next_addr_req_n;
	wire snoop = ~bus.snoop_addr_valid_n;
	// a mask seen in the first edges after reset still beats the first strobe
	wire settled = (settle_ff == RST_SETTLE);
	// exemptions, mask sampled as a level each edge
	wire mask_on = ~bus.bit20_mask_in_n & i_real_mode & ~i_sys_mgmt_state & ~i_req_writeback;
	addr_t masked_addr;
	always_comb begin
		masked_addr = i_req_addr;
		if (mask_on) begin
			masked_addr[MASK_IDX] = 1'b0;
		end
	end
	wire gen_parity = ^masked_addr[ADDR_W-1:LINE_LO_IDX];
	wire last_ack = ack & (beats_ff == BEAT_SINGLE);
	wire addr_release = na | last_ack;
	// under hold only writebacks may start
	wire may_start = settled & i_req_valid & ~backoff & ~i_hold_req & ~surrender_ff
		& (~bus.addr_float_req | i_req_writeback);
	wire pipe_start = (state_ff == ST_DATA) & na & may_start;
	wire idle_start = (state_ff == ST_IDLE) & may_start;
	wire start = idle_start | pipe_start;
	// surrender only once the bus is quiet; floats go with the grant edge
	wire nxt_surrender = i_hold_req & (surrender_ff | (state_ff == ST_IDLE && !start));
	wire snoop_perr = snoop & (^{bus.addr[ADDR_W-1:LINE_LO_IDX], bus.addr_parity_bit});

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_state = ST_ADDR;
				end
			end
			ST_ADDR: begin
				nxt_state = ST_DATA;
			end
			ST_DATA: begin
				// last ack leaves one idle state
				if (last_ack) begin
					nxt_state = ST_GAP;
				end
				if (pipe_start) begin
					nxt_state = ST_ADDR;
				end
			end
			ST_GAP: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// backoff aborts; request stays pending to restart
		if (backoff) begin
			nxt_state = ST_IDLE;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			beats_ff <= BEAT_SINGLE;
			burst_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (start) begin
				beats_ff <= i_req_burst ? BEAT_BURST : BEAT_SINGLE;
				burst_ff <= i_req_burst;
			end else if (ack && state_ff == ST_DATA && beats_ff != BEAT_SINGLE) begin
				beats_ff <= beats_ff - 3'h1;
			end
		end
	end

	// ----------------------------------------
	// address and parity
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_ff <= ADDR_RST;
			parity_ff <= 1'b0;
		end else if (start) begin
			// new address only on a start, held otherwise
			addr_ff <= masked_addr;
			parity_ff <= gen_parity;
		end
	end

	// address floats on hold, backoff or surrender, strobe on the last two; both float in reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_ff <= 1'b0;
			backoff_ff <= 1'b0;
			surrender_ff <= 1'b0;
			oe_addr_ff <= 1'b0;
			oe_strobe_ff <= 1'b0;
			settle_ff <= 2'h0;
		end else begin
			hold_ff <= bus.addr_float_req;
			backoff_ff <= backoff;
			surrender_ff <= nxt_surrender;
			if (!settled) begin
				settle_ff <= settle_ff + 2'h1;
			end
			oe_addr_ff <= ~(bus.addr_float_req | backoff | nxt_surrender);
			// strobe float; hold leaves it driven
			oe_strobe_ff <= ~(backoff | nxt_surrender);
		end
	end

	// ----------------------------------------
	// strobes, snoop, parity error
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strobe_ff <= 1'b0;
			taken_ff <= 1'b0;
			done_ff <= 1'b0;
			snoop_v_ff <= 1'b0;
			snoop_addr_ff <= ADDR_RST;
			perr_n_ff <= 1'b1;
		end else begin
			strobe_ff <= start;
			taken_ff <= start;
			done_ff <= (state_ff == ST_DATA) & last_ack & ~backoff;
			snoop_v_ff <= snoop & ~oe_addr_ff;
			if (snoop) begin
				snoop_addr_ff <= bus.addr;
			end
			perr_n_ff <= ~(snoop_perr & ~oe_addr_ff);
		end
	end

	assign bus.cpu_addr = addr_ff;
	assign bus.cpu_parity = parity_ff;
	assign bus.cpu_addr_oe = oe_addr_ff;
	assign bus.cycle_start_strobe_n = ~strobe_ff;
	assign bus.cycle_start_strobe_dup_n = ~strobe_ff;
	assign bus.strobe_oe = oe_strobe_ff;
	assign bus.addr_parity_err_n = perr_n_ff;
	assign bus.bus_surrender_ack = surrender_ff;
	assign o_req_taken = taken_ff;
	assign o_cycle_done = done_ff;
	assign o_snoop_valid = snoop_v_ff;
	assign o_snoop_addr = snoop_addr_ff;
endmodule

// ==== hw/sys_addr_phase.sv ====
// chipset end: mask drive, hold and snoop issue, acknowledges, parity watch
module sys_addr_phase (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// link
	addr_phase_if.sys bus,
	// controller side
	input wire logic i_mask,
	input wire logic i_float_req,
	input wire logic i_snoop_go,
	input wire addr_phase_pkg::addr_t i_snoop_addr,
	input wire logic i_ack,
	input wire logic i_next_addr,
	input wire logic i_backoff,
	input wire logic i_parity_flip,
	// observed
	output logic o_cycle_seen,
	output addr_phase_pkg::addr_t o_cycle_addr,
	output logic o_parity_err
);
	import addr_phase_pkg::*;

	logic mask_n_ff;
	logic float_ff;
	logic snoop_n_ff;
	addr_t saddr_ff;
	logic sparity_ff;
	logic soe_ff;
	logic ack_n_ff;
	logic na_n_ff;
	logic backoff_req_n_ff;
	logic seen_ff;
	addr_t caddr_ff;
	logic perr_ff;

	// ----------------------------------------
	// drive toward the processor
	// ----------------------------------------
	wire cpu_floated = ~bus.cpu_addr_oe;
	wire snoop_parity = ^i_snoop_addr[ADDR_W-1:LINE_LO_IDX];
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_n_ff <= 1'b1;
			float_ff <= 1'b0;
			snoop_n_ff <= 1'b1;
			saddr_ff <= ADDR_RST;
			sparity_ff <= 1'b0;
			soe_ff <= 1'b0;
			ack_n_ff <= 1'b1;
			na_n_ff <= 1'b1;
			backoff_req_n_ff <= 1'b1;
		end else begin
			// registered level, held as long as asked
			mask_n_ff <= ~i_mask;
			float_ff <= i_float_req;
			backoff_req_n_ff <= ~i_backoff;
			ack_n_ff <= ~i_ack;
			na_n_ff <= ~i_next_addr;
			soe_ff <= i_float_req & cpu_floated;
			saddr_ff <= i_snoop_addr;
			// wrong parity on request, so the processor's check can be exercised
			sparity_ff <= snoop_parity ^ i_parity_flip;
			snoop_n_ff <= ~(i_snoop_go & i_float_req & cpu_floated);
		end
	end

	// ----------------------------------------
	// observe the processor
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_ff <= 1'b0;
			caddr_ff <= ADDR_RST;
			perr_ff <= 1'b0;
		end else begin
			seen_ff <= ~bus.cycle_start_strobe_n & bus.strobe_oe;
			if (!bus.cycle_start_strobe_n && bus.strobe_oe) begin
				caddr_ff <= bus.addr;
			end
			perr_ff <= ~bus.addr_parity_err_n;
		end
	end

	assign bus.bit20_mask_in_n = mask_n_ff;
	assign bus.addr_float_req = float_ff;
	assign bus.snoop_addr_valid_n = snoop_n_ff;
	assign bus.sys_addr = saddr_ff;
	assign bus.sys_parity = sparity_ff;
	assign bus.sys_addr_oe = soe_ff;
	assign bus.transfer_ack_n = ack_n_ff;
	assign bus.next_addr_req_n = na_n_ff;
	assign bus.backoff_req_n = backoff_req_n_ff;
	assign o_cycle_seen = seen_ff;
	assign o_cycle_addr = caddr_ff;
	assign o_parity_err = perr_ff;
endmodule

// ==== tb/addr_phase_properties.sv ====
// assertions on the address-phase link
module addr_phase_properties
	import addr_phase_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// link signals
	input wire addr_t addr,
	input wire logic addr_parity_bit,
	input wire logic cpu_addr_oe,
	input wire logic cycle_start_strobe_n,
	input wire logic cycle_start_strobe_dup_n,
	input wire logic strobe_oe,
	input wire logic addr_parity_err_n,
	input wire logic bus_surrender_ack,
	input wire logic addr_float_req,
	input wire logic snoop_addr_valid_n,
	input wire logic transfer_ack_n,
	input wire logic next_addr_req_n,
	input wire logic backoff_req_n
);
	// ------------------------------
	// cycle tracking and properties
	// ------------------------------
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire par_ok = addr_parity_bit == ^addr[ADDR_W-1:LINE_LO_IDX];
	wire start = !cycle_start_strobe_n && strobe_oe;
	logic busy_ff;
	// busy until the first ack, next-addr or backoff, so later burst acks go unchecked
	wire nxt_busy = start | busy_ff & transfer_ack_n & next_addr_req_n & backoff_req_n;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_ff <= 1'h0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end
	dup_strobe_a: assert property (cycle_start_strobe_dup_n == cycle_start_strobe_n)
		else $error("strobe copy differs");
	strobe_pulse_a: assert property ($fell(cycle_start_strobe_n) |=> cycle_start_strobe_n)
		else $error("strobe longer than one clock");
	parity_even_a: assert property (cpu_addr_oe |-> par_ok)
		else $error("driven parity odd");
	float_addr_a: assert property ((addr_float_req || !backoff_req_n) |=> !cpu_addr_oe)
		else $error("address not floated");
	float_strobe_a: assert property (!backoff_req_n |=> !strobe_oe)
		else $error("strobe not floated");
	surrender_a: assert property (bus_surrender_ack |-> !strobe_oe && !cpu_addr_oe)
		else $error("driving while surrendered");
	addr_hold_a: assert property (busy_ff && cpu_addr_oe && $past(cpu_addr_oe) |-> $stable(addr))
		else $error("address moved in cycle");
	ack_gap_a: assert property (busy_ff && !transfer_ack_n && next_addr_req_n |=>
		cycle_start_strobe_n)
		else $error("no idle state after ack");
	snoop_check_a: assert property (!snoop_addr_valid_n && !cpu_addr_oe |=>
		addr_parity_err_n == $past(par_ok))
		else $error("parity flag wrong");
	err_pulse_a: assert property (!addr_parity_err_n |=> addr_parity_err_n)
		else $error("parity flag too long");
	err_timing_a: assert property (!addr_parity_err_n |-> !$past(snoop_addr_valid_n))
		else $error("parity flag without snoop");
	cover property (!next_addr_req_n && busy_ff);
	cover property (start);
	cover property (!snoop_addr_valid_n && !cpu_addr_oe);
	cover property (!backoff_req_n && busy_ff);
endmodule

// ==== tb/cpu_bus_address_phase_tb.sv ====
// testbench for the address-phase link
module cpu_bus_address_phase_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import addr_phase_pkg::*;
	// ------------------------------
	// stimulus and instances
	// ------------------------------
	localparam addr_t ADDR_A = 29'h0123457;
	localparam addr_t ADDR_M = ADDR_A & ~(29'h1 << MASK_IDX);
	logic i_clock = 1'h0;
	logic i_rst_n = 1'h0;
	logic req_valid = 1'h0, req_burst = 1'h0, req_wb = 1'h0, sys_mgmt_state = 1'h0;
	logic real_mode = 1'h1, hold_req = 1'h0, mask = 1'h0, float_req = 1'h0;
	logic snoop_go = 1'h0, ack = 1'h0, backoff = 1'h0;
	logic next_addr = 1'h0, parity_flip = 1'h0;
	addr_t req_addr = '0, snoop_addr = '0, snoop_got, cycle_addr;
	logic req_taken, cycle_done, snoop_valid, cycle_seen, parity_err;
	int error_cnt = 0, n_tests = 0;
	addr_phase_if link();
	wire [3:0] evt = {link.bus_surrender_ack, snoop_valid, cycle_done, req_taken};
	always #5 i_clock = ~i_clock;
	cpu_addr_phase cpu_addr_phase_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(link),
		.i_req_valid(req_valid), .i_req_addr(req_addr), .i_req_burst(req_burst),
		.i_req_writeback(req_wb), .i_sys_mgmt_state(sys_mgmt_state), .i_real_mode(real_mode),
		.i_hold_req(hold_req), .o_req_taken(req_taken), .o_cycle_done(cycle_done),
		.o_snoop_valid(snoop_valid), .o_snoop_addr(snoop_got));
	sys_addr_phase sys_addr_phase_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(link),
		.i_mask(mask), .i_float_req(float_req), .i_snoop_go(snoop_go),
		.i_snoop_addr(snoop_addr), .i_ack(ack), .i_next_addr(next_addr), .i_backoff(backoff),
		.i_parity_flip(parity_flip),
		.o_cycle_seen(cycle_seen), .o_cycle_addr(cycle_addr), .o_parity_err(parity_err));
	addr_phase_properties addr_phase_properties_inst (.i_clock(i_clock),
		.i_rst_n(i_rst_n), .addr(link.addr), .addr_parity_bit(link.addr_parity_bit),
		.cpu_addr_oe(link.cpu_addr_oe), .cycle_start_strobe_n(link.cycle_start_strobe_n),
		.cycle_start_strobe_dup_n(link.cycle_start_strobe_dup_n), .strobe_oe(link.strobe_oe),
		.addr_parity_err_n(link.addr_parity_err_n), .bus_surrender_ack(link.bus_surrender_ack),
		.addr_float_req(link.addr_float_req), .snoop_addr_valid_n(link.snoop_addr_valid_n),
		.transfer_ack_n(link.transfer_ack_n), .next_addr_req_n(link.next_addr_req_n),
		.backoff_req_n(link.backoff_req_n));
	task step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait on one of the completion events
	task wait_evt(input int b);
		int k;
		k = 0;
		while (evt[b] !== 1'h1 && k < 40) begin
			step(1);
			k++;
		end
		check(evt[b], 1'h1);
	endtask
	// the processor's own address drive is compared, floated or not
	task run_cycle(input addr_t a, input addr_t exp, input logic burst, input logic wb);
		req_addr = a;
		req_burst = burst;
		req_wb = wb;
		req_valid = 1'h1;
		wait_evt(0);
		req_valid = 1'h0;
		check(link.cpu_addr, exp);
		ack = 1'h1;
		step(1);
		check(cycle_seen, 1'h1);
		if (burst) begin
			step(BEAT_BURST - BEAT_SINGLE);
		end
		ack = 1'h0;
		wait_evt(1);
	endtask
	task finish_test();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
	initial begin
		step(2);
		i_rst_n = 1'h1;
		run_cycle(ADDR_A, ADDR_A, 1'h0, 1'h0);
		mask = 1'h1;
		step(3);
		run_cycle(ADDR_A, ADDR_M, 1'h1, 1'h0);
		run_cycle(ADDR_A, ADDR_A, 1'h0, 1'h1);
		sys_mgmt_state = 1'h1;
		run_cycle(ADDR_A, ADDR_A, 1'h0, 1'h0);
		sys_mgmt_state = 1'h0;
		mask = 1'h0;
		req_valid = 1'h1;
		wait_evt(0);
		backoff = 1'h1;
		step(3);
		check(link.strobe_oe, 1'h0);
		backoff = 1'h0;
		run_cycle(ADDR_A, ADDR_A, 1'h0, 1'h0);
		req_addr = ADDR_A;
		req_valid = 1'h1;
		wait_evt(0);
		req_addr = ADDR_M;
		next_addr = 1'h1;
		ack = 1'h1;
		step(1);
		next_addr = 1'h0;
		ack = 1'h0;
		step(1);
		check(req_taken, 1'h1);
		check(cycle_done, 1'h1);
		check(link.cpu_addr, ADDR_M);
		req_valid = 1'h0;
		ack = 1'h1;
		step(1);
		ack = 1'h0;
		wait_evt(1);
		float_req = 1'h1;
		req_valid = 1'h1;
		repeat (6) begin
			step(1);
			check(req_taken, 1'h0);
		end
		check(link.cpu_addr_oe, 1'h0);
		check(link.strobe_oe, 1'h1);
		req_valid = 1'h0;
		snoop_addr = ADDR_M;
		snoop_go = 1'h1;
		step(1);
		snoop_go = 1'h0;
		wait_evt(2);
		check(snoop_got[ADDR_W-1:LINE_LO_IDX], ADDR_M[ADDR_W-1:LINE_LO_IDX]);
		step(1);
		check(parity_err, 1'h0);
		parity_flip = 1'h1;
		snoop_go = 1'h1;
		step(1);
		parity_flip = 1'h0;
		snoop_go = 1'h0;
		wait_evt(2);
		step(1);
		check(parity_err, 1'h1);
		step(1);
		check(parity_err, 1'h0);
		run_cycle(ADDR_A, ADDR_A, 1'h0, 1'h1);
		float_req = 1'h0;
		step(3);
		check(link.cpu_addr_oe, 1'h1);
		hold_req = 1'h1;
		wait_evt(3);
		check(link.cpu_addr_oe, 1'h0);
		hold_req = 1'h0;
		step(3);
		mask = 1'h1;
		i_rst_n = 1'h0;
		step(2);
		i_rst_n = 1'h1;
		run_cycle(ADDR_A, ADDR_M, 1'h0, 1'h0);
		mask = 1'h0;
		run_cycle(ADDR_M, ADDR_M, 1'h1, 1'h0);
		check(cycle_addr, ADDR_M);
		finish_test();
	end
endmodule
